// >>> pkg/apc_defs.svh
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// data inputs checked per mode, bit 0 is data line 1
`define APC_MASK_SINGLE   25'h1FFFFB6
`define APC_MASK_FIRST    25'h0003FB6
`define APC_MASK_SECOND   25'h0001FBF

// configuration pin codes {hi, lo}
`define APC_CFG_SINGLE    2'h0
`define APC_CFG_FIRST     2'h2
`define APC_CFG_SECOND    2'h3

// cycles the error output stays low after an error
`define APC_HOLD_CYCLES   2'h2

// reset values
`define APC_RST_DATA      25'h0000000
`define APC_RST_BIT       1'h0
`define APC_RST_RELEASED  1'h1

`endif

// >>> pkg/apc_pkg.sv
//------------------------------------------------------------------------------
// types of the address parity checker
//------------------------------------------------------------------------------
package apc_pkg;

    // operating mode, one-hot
    typedef enum logic [2:0] {
        APC_SINGLE = 3'h1,
        APC_FIRST  = 3'h2,
        APC_SECOND = 3'h4
    } apc_mode_type;

    // one sampled set of pins
    typedef struct packed {
        logic [24:0] data;   // registered data lines
        logic        par;    // parity bit
        logic [1:0]  cfg;    // {cfg_sel_hi, cfg_sel_lo}
    } apc_in_type;

endpackage

// >>> rtl/apc_address_parity_checker.sv
`timescale 1ns/1ps
`include "apc_defs.svh"

module apc_address_parity_checker (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // data, parity and configuration pins
    input  wire logic [24:0] dataLines,
    input  wire logic        parityIn,
    input  wire logic        cfgSelLo,
    input  wire logic        cfgSelHi,
    // open-drain error pin, active low, oe low while driving
    output logic             parityErrorN,
    output logic             parityErrorNOe,
    // partial parity to a cascaded device
    output logic             partialParityOut
);

    //--------------------------------------------------------------------------
    // input synchroniser
    //--------------------------------------------------------------------------
    apc_pkg::apc_in_type     syncA_r;      // first stage, read only by syncB_r
    apc_pkg::apc_in_type     syncB_r;      // second stage, the registered inputs
    logic [24:0]             dataDly_r;    // data of the previous edge
    apc_pkg::apc_mode_type   mode_r;       // decoded mode
    logic                    ppo_r;        // parity sum, also cascade output
    logic                    errOut_r;     // error pin level
    logic                    errOe_r;      // error pin enable, low while driving
    logic [1:0]              holdCnt_r;    // remaining hold cycles
    logic [24:0]             mask;         // checked data lines
    logic                    chkBit;       // odd count over data and parity
    logic                    errEvent;     // a parity error reaches the output

    // two flops for every pin before any logic looks at it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncA_r <= '{`APC_RST_DATA, `APC_RST_BIT, `APC_CFG_SINGLE};
            syncB_r <= '{`APC_RST_DATA, `APC_RST_BIT, `APC_CFG_SINGLE};
        end else begin
            syncA_r <= '{dataLines, parityIn, {cfgSelHi, cfgSelLo}};
            syncB_r <= syncA_r;
        end
    end

    //--------------------------------------------------------------------------
    // mode decode
    //--------------------------------------------------------------------------
    // unused code {hi=0, lo=1} falls back to single operation
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= apc_pkg::APC_SINGLE;
        end else begin
            unique case (syncB_r.cfg)
                `APC_CFG_FIRST:  mode_r <= apc_pkg::APC_FIRST;
                `APC_CFG_SECOND: mode_r <= apc_pkg::APC_SECOND;
                default:         mode_r <= apc_pkg::APC_SINGLE;
            endcase
        end
    end

    // data lines covered by the parity in each mode
    always_comb begin
        unique case (mode_r)
            apc_pkg::APC_FIRST:  mask = `APC_MASK_FIRST;
            apc_pkg::APC_SECOND: mask = `APC_MASK_SECOND;
            default:             mask = `APC_MASK_SINGLE;
        endcase
    end

    //--------------------------------------------------------------------------
    // parity check
    //--------------------------------------------------------------------------
    // parity trails its data by one edge, so data is delayed to meet it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dataDly_r <= `APC_RST_DATA;
        end else begin
            dataDly_r <= syncB_r.data;
        end
    end

    // even parity: an odd count of ones is an error
    assign chkBit = (^(dataDly_r & mask)) ^ syncB_r.par;

    // partial parity, one edge after the check
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ppo_r <= `APC_RST_BIT;
        end else begin
            ppo_r <= chkBit;
        end
    end

    // first of pair reports one edge earlier than the other modes
    assign errEvent = (mode_r == apc_pkg::APC_FIRST) ? chkBit : ppo_r;

    //--------------------------------------------------------------------------
    // error latch
    //--------------------------------------------------------------------------
    // a new error restarts the hold; reset releases the pin at once
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            errOut_r  <= `APC_RST_RELEASED;
            errOe_r   <= `APC_RST_RELEASED;
            holdCnt_r <= 2'h0;
        end else if (errEvent) begin
            // drive low
            errOut_r  <= 1'h0;
            errOe_r   <= 1'h0;
            holdCnt_r <= `APC_HOLD_CYCLES - 2'h1;
        end else if (holdCnt_r != 2'h0) begin
            // keep low while the hold runs
            holdCnt_r <= holdCnt_r - 2'h1;
        end else begin
            // release the pin
            errOut_r  <= 1'h1;
            errOe_r   <= 1'h1;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign parityErrorN     = errOut_r;
    assign parityErrorNOe   = errOe_r;
    assign partialParityOut = ppo_r;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    // decode follows the settled configuration pins
    property p_mode_decode;
        @(posedge core_clk) disable iff (!rstn)
        (syncB_r.cfg == `APC_CFG_SECOND) |=> (mode_r == apc_pkg::APC_SECOND);
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("mode not second of pair");

    // lo pin high with hi pin low selects single
    property p_mode_bad;
        @(posedge core_clk) disable iff (!rstn)
        (syncB_r.cfg == 2'h1) |=> (mode_r == apc_pkg::APC_SINGLE);
    endproperty
    a_mode_bad: assert property (p_mode_bad)
        else $error("unused code not single");

    // first of pair: error pin low one edge after the check
    property p_first_lat;
        @(posedge core_clk) disable iff (!rstn)
        (mode_r == apc_pkg::APC_FIRST && chkBit) |=> !parityErrorNOe;
    endproperty
    a_first_lat: assert property (p_first_lat)
        else $error("first of pair error late");

    // second of pair: error pin low two edges after the check
    property p_second_lat;
        @(posedge core_clk) disable iff (!rstn)
        (mode_r == apc_pkg::APC_SECOND && chkBit ##1 mode_r == apc_pkg::APC_SECOND)
            |=> !parityErrorNOe;
    endproperty
    a_second_lat: assert property (p_second_lat)
        else $error("second of pair error late");

    // single: error pin low two edges after the check
    property p_single_lat;
        @(posedge core_clk) disable iff (!rstn)
        (mode_r == apc_pkg::APC_SINGLE && chkBit ##1 mode_r == apc_pkg::APC_SINGLE)
            |=> !parityErrorNOe;
    endproperty
    a_single_lat: assert property (p_single_lat)
        else $error("single error late");

    // no error means no early drive in the slow modes
    property p_no_false;
        @(posedge core_clk) disable iff (!rstn)
        (mode_r != apc_pkg::APC_FIRST && !ppo_r && holdCnt_r == 2'h0) |=>
            parityErrorNOe;
    endproperty
    a_no_false: assert property (p_no_false)
        else $error("error pin driven without cause");

    // once driven low it stays low for two cycles
    property p_hold;
        @(posedge core_clk) disable iff (!rstn)
        $fell(parityErrorNOe) |-> !parityErrorNOe [*2];
    endproperty
    a_hold: assert property (p_hold)
        else $error("error released early");

    // level and enable always agree
    property p_pin_pair;
        @(posedge core_clk) disable iff (!rstn)
        parityErrorN == parityErrorNOe;
    endproperty
    a_pin_pair: assert property (p_pin_pair)
        else $error("error pin level and enable differ");

    // partial parity is the even-parity sum of the word two edges back
    property p_ppo;
        @(posedge core_clk) disable iff (!rstn)
        partialParityOut ==
            ((^($past(syncB_r.data, 2) & $past(mask))) ^ $past(syncB_r.par));
    endproperty
    a_ppo: assert property (p_ppo)
        else $error("partial parity wrong");

    // main scenarios
    c_first_err: cover property (@(posedge core_clk) disable iff (!rstn)
        mode_r == apc_pkg::APC_FIRST && $fell(parityErrorNOe));
    c_second_err: cover property (@(posedge core_clk) disable iff (!rstn)
        mode_r == apc_pkg::APC_SECOND && $fell(parityErrorNOe));
    c_single_release: cover property (@(posedge core_clk) disable iff (!rstn)
        mode_r == apc_pkg::APC_SINGLE && $rose(parityErrorNOe));
    // back-to-back errors keep the pin low past the plain hold
    c_hold_restart: cover property (@(posedge core_clk) disable iff (!rstn)
        $fell(parityErrorNOe) ##1 !parityErrorNOe ##1 !parityErrorNOe);
    // unused configuration code runs as a single device
    c_unused_code: cover property (@(posedge core_clk) disable iff (!rstn)
        syncB_r.cfg == 2'h1 && $fell(parityErrorNOe));

endmodule

// >>> dv/apc_ctrl_model.sv
`timescale 1ns/1ps

module apc_ctrl_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // next word, mode mask and error request
    input  wire logic [24:0] word,
    input  wire logic [24:0] lineMask,
    input  wire logic        flipPar,
    // pins towards the checker
    output logic [24:0]      dataPins,
    output logic             parityPin
);
    logic parNxt;  // parity owed for the word now on the pins

    // words launch on the falling edge, parity one cycle behind
    // in second-of-pair runs the parity pin stands in for the
    // partial parity of a first device wired to it
    always_ff @(negedge core_clk or negedge rstn) begin
        if (!rstn) begin
            // pins held low at known levels around reset
            dataPins  <= 25'h0000000;
            parityPin <= 1'h0;
            parNxt    <= 1'h0;
        end else begin
            dataPins  <= word;
            parityPin <= parNxt;
            parNxt    <= (^(word & lineMask)) ^ flipPar;
        end
    end
endmodule

// >>> dv/address_parity_checker_tb_top.sv
`timescale 1ns/1ps
`include "apc_defs.svh"

module address_parity_checker_tb_top;
    logic        core_clk, rstn, cfgSelLo, cfgSelHi, flip, parityIn;
    logic        errOut, errOe, partial_parity_out, ePrev;
    logic [24:0] word, mask, dataBus;
    logic        expQ[$];  // expected error enable per cycle
    logic        ppoQ[$];  // expected partial parity per cycle
    int          n_fail, num_checks, lat;

    apc_address_parity_checker apc_address_parity_checker_inst (
        .core_clk(core_clk), .rstn(rstn), .dataLines(dataBus), .parityIn(parityIn),
        .cfgSelLo(cfgSelLo), .cfgSelHi(cfgSelHi), .parityErrorN(errOut),
        .parityErrorNOe(errOe), .partialParityOut(partial_parity_out));

    apc_ctrl_model apc_ctrl_model_inst (
        .core_clk(core_clk), .rstn(rstn), .word(word), .lineMask(mask),
        .flipPar(flip), .dataPins(dataBus), .parityPin(parityIn));

    // free running clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // compare one value and count it
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one word per cycle, notes the outcome; error held two cycles
    task automatic step(input logic [24:0] w, input logic f);
        @(posedge core_clk);
        #1;
        word = w;
        flip = f;
        expQ.push_back(~(f | ePrev));
        ppoQ.push_back(f);
        ePrev = f;
    endtask

    // reset into one configuration code, then traffic
    task automatic run_mode(input logic [1:0] code);
        @(negedge core_clk);
        rstn = 1'b0;
        {cfgSelHi, cfgSelLo} = code;
        #2;
        check(errOe, 1'h1);
        check(errOut, 1'h1);
        expQ.delete();
        ppoQ.delete();
        {ePrev, word, flip} = 27'h0;
        if (code == `APC_CFG_FIRST) mask = `APC_MASK_FIRST;
        else if (code == `APC_CFG_SECOND) mask = `APC_MASK_SECOND;
        else mask = `APC_MASK_SINGLE;
        lat = (code == `APC_CFG_FIRST) ? 3 : 4;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) step(25'h0, 1'h0);
        // walking ones expose a wrong line set
        for (int i = 0; i < 25; i++) step(25'h1 << i, 1'h0);
        // lone error, then back-to-back errors restarting the hold
        step(mask, 1'h1);
        repeat (3) step(25'h0, 1'h0);
        repeat (3) step(25'h0, 1'h1);
        repeat (40) step(25'($urandom), ($urandom % 4) == 0);
        // error still held when the next reset lands
        step(25'h0, 1'h1);
        repeat (lat + 1) step(25'h0, 1'h0);
    endtask

    // watches outputs, compares against the oldest notes
    always @(posedge core_clk) begin
        #2;
        if (rstn === 1'b1 && expQ.size() > lat + 1) begin
            check(errOe, expQ[0]);
            check(errOut, expQ[0]);
            void'(expQ.pop_front());
        end
        if (rstn === 1'b1 && ppoQ.size() > 4) begin
            check(partial_parity_out, ppoQ.pop_front());
        end
    end

    // watchdog against a hang
    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end

    // main sequence over all four configuration codes
    initial begin
        {rstn, cfgSelLo, cfgSelHi, flip, ePrev} = 5'h0;
        word = 25'h0;
        mask = `APC_MASK_SINGLE;
        lat = 4;
        n_fail = 0;
        num_checks = 0;
        void'($urandom(93));
        for (int c = 0; c < 4; c++) run_mode(2'(c));
        run_mode(`APC_CFG_SINGLE);
        wrap_up();
    end
endmodule
